// *** hw/cphc_map.svh ***
/*
  Constants of the core pipeline control: the reset program counter, instruction field
  positions, fetch steps and the bytecode decode length.
  Assumes no inclusion by hw/cphc_pkg.sv; included by hw/cphc_pipe.sv by bare name.
*/
`ifndef CPHC_MAP_SVH
`define CPHC_MAP_SVH

`define CPHC_RESET_PC     32'h0000_0000
`define CPHC_STEP_NATIVE  32'h0000_0004
`define CPHC_STEP_COMPACT 32'h0000_0002
`define CPHC_STEP_BYTE    32'h0000_0001
`define CPHC_BC_DEC_CYC   2

// Native word layout
`define CPHC_F_OP   28
`define CPHC_F_SIZE 26
`define CPHC_F_RD   22
`define CPHC_F_RN   18
`define CPHC_F_RM   14
`define CPHC_W_IMM  14

// Compressed halfword layout
`define CPHC_H_OP 13
`define CPHC_H_RD 10
`define CPHC_H_RN 7
`define CPHC_H_RM 4

// Bytecode layout
`define CPHC_B_OP 5
`define CPHC_B_RD 3
`define CPHC_B_RN 1

`endif

// *** hw/cphc_pkg.sv ***
/*
  Types of the core pipeline control: opcodes, sizes, instruction states,
  forwarding selects and the stage registers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cphc_pkg;

  typedef enum logic [2:0] {
    OP_NOP   = 3'b000,
    OP_ADD   = 3'b001,
    OP_ADDI  = 3'b010,
    OP_LOAD  = 3'b011,
    OP_STORE = 3'b100,
    OP_CPLD  = 3'b101,
    OP_CPST  = 3'b110,
    OP_SWAP  = 3'b111
  } cphc_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } cphc_size_t;

  typedef enum logic [1:0] {
    ISA_NATIVE   = 2'b00,
    ISA_COMPACT  = 2'b01,
    ISA_BYTECODE = 2'b10
  } cphc_isa_t;

  typedef enum logic [1:0] {
    FWD_RF  = 2'b00,
    FWD_MEM = 2'b01,
    FWD_WB  = 2'b10
  } cphc_fwd_t;

  typedef struct packed {
    logic        valid;
    cphc_isa_t   isa;
    logic [31:0] pc;
    logic [31:0] word;
  } cphc_dec_t;

  typedef struct packed {
    logic        valid;
    cphc_op_t    op;
    cphc_size_t  size;
    logic [3:0]  rd;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic        use_rn;
    logic        use_rm;
    logic        wr;
    logic [31:0] imm;
  } cphc_exe_t;

  typedef struct packed {
    logic        valid;
    cphc_op_t    op;
    cphc_size_t  size;
    logic [3:0]  rd;
    logic        wr;
    logic [31:0] res;
  } cphc_mem_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  rd;
    logic        wr;
    logic [31:0] data;
  } cphc_wb_t;

  typedef struct packed {
    logic        req;
    logic        we;
    cphc_size_t  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cphc_dreq_t;

endpackage : cphc_pkg

// *** hw/cphc_hazard.sv ***
/*
  Register hazard detection: operand forwarding selects for the execute
  stage and the load-use stall request for the decode stage.
  Assumes stage registers from cphc_pipe; purely combinational.
*/
`timescale 1ns/1ps

module cphc_hazard (
  input  cphc_pkg::cphc_exe_t dec_info,
  input  cphc_pkg::cphc_exe_t ex_st,
  input  cphc_pkg::cphc_mem_t mem_st,
  input  cphc_pkg::cphc_wb_t  wb_st,
  output logic                load_use,
  output cphc_pkg::cphc_fwd_t fwd_a,
  output cphc_pkg::cphc_fwd_t fwd_b
);
  import cphc_pkg::*;

  logic mem_fwd_ok;
  logic ex_is_load;

  function automatic cphc_fwd_t pick(input logic [3:0] r, input logic mem_ok, input cphc_mem_t m,
                                     input cphc_wb_t w);
    pick = FWD_RF;
    if (w.valid && w.wr && w.rd == r) begin
      pick = FWD_WB;
    end
    // Youngest producer wins
    if (mem_ok && m.rd == r) begin
      pick = FWD_MEM;
    end
  endfunction : pick

  always_comb begin
    // Load data arrives only at the end of memory, so no forward from there
    mem_fwd_ok = mem_st.valid && mem_st.wr && mem_st.op != OP_LOAD && mem_st.op != OP_SWAP;
    fwd_a      = pick(ex_st.rn, mem_fwd_ok, mem_st, wb_st);
    fwd_b      = pick(ex_st.rm, mem_fwd_ok, mem_st, wb_st);
    ex_is_load = ex_st.valid && ex_st.wr && (ex_st.op == OP_LOAD || ex_st.op == OP_SWAP);
    load_use   = ex_is_load && dec_info.valid &&
                 ((dec_info.use_rn && dec_info.rn == ex_st.rd) ||
                  (dec_info.use_rm && dec_info.rm == ex_st.rd));
  end

endmodule : cphc_hazard

// *** hw/cphc_pipe.sv ***
/*
  Core pipeline control: fetch, decode, execute, memory and writeback
  stages with separate instruction and data interfaces, size handling,
  forwarding and interlocks, and a register bank in flip-flops.
  Assumes instruction and data memories answer in the cycle of the request
  with a ready input; inputs are synchronous to clk.
*/
// Behaviour
// - Native state runs five single-cycle stages
// - Bytecode state decode takes two cycles
// - Fetch address is the program counter
// - Each stage holds a successive instruction
// - Separate instruction and data buses, concurrent
// - Only memory-class instructions touch data bus
// - Byte, halfword and word data sizes
// - Detect register hazards, stall or forward
// - Native, compressed and bytecode instruction states
`timescale 1ns/1ps
`include "cphc_map.svh"

module cphc_pipe (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  cphc_pkg::cphc_isa_t       isa_state,
  input  wire logic [31:0]          imem_rdata,
  input  wire logic                 imem_ready,
  input  wire logic [31:0]          dmem_rdata,
  input  wire logic                 dmem_ready,
  output logic                      imem_req,
  output logic [31:0]               pc,
  output cphc_pkg::cphc_dreq_t      dmem,
  output cphc_pkg::cphc_wb_t        retire,
  output logic                      align_err,
  output logic                      stall
);
  import cphc_pkg::*;

  logic [31:0] pc_ff,       nxt_pc;
  logic        ireq_ff,     nxt_ireq;
  cphc_dec_t   dec_ff,      nxt_dec;
  cphc_exe_t   ex_ff,       nxt_ex;
  cphc_mem_t   mem_ff,      nxt_mem;
  cphc_wb_t    wb_ff,       nxt_wb;
  cphc_dreq_t  dreq_ff,     nxt_dreq;
  logic        bc_ph_ff,    nxt_bc_ph;
  logic        swap_ph_ff,  nxt_swap_ph;
  logic [31:0] swap_ld_ff,  nxt_swap_ld;
  logic        aerr_ff,     nxt_aerr;
  logic        stall_ff,    nxt_stall;
  logic [31:0] rf_ff [16];
  logic [31:0] nxt_rf [16];

  cphc_exe_t   dx;
  cphc_fwd_t   fwd_a;
  cphc_fwd_t   fwd_b;
  logic        load_use;
  logic        bc_wait;
  logic        dec_hold;
  logic        mem_wait;
  logic        swap_first;
  logic        mem_hold;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] ex_addr;
  logic        misalign;

  // Own encoding; each state expands to one common format
  function automatic cphc_exe_t decode_instr(input cphc_dec_t d);
    cphc_exe_t   e;
    logic [15:0] h;
    logic [7:0]  b;
    e = '0;
    h = d.pc[1] ? d.word[31:16] : d.word[15:0];
    b = d.word[{d.pc[1:0], 3'b000} +: 8];
    case (d.isa)
      ISA_COMPACT: begin
        e.op   = cphc_op_t'(h[`CPHC_H_OP +: 3]);
        e.size = SZ_WORD;
        e.rd   = {1'b0, h[`CPHC_H_RD +: 3]};
        e.rn   = {1'b0, h[`CPHC_H_RN +: 3]};
        e.rm   = {1'b0, h[`CPHC_H_RM +: 3]};
        e.imm  = {28'h0000000, h[3:0]};
      end
      ISA_BYTECODE: begin
        e.op   = cphc_op_t'(b[`CPHC_B_OP +: 3]);
        e.size = SZ_WORD;
        e.rd   = {2'b00, b[`CPHC_B_RD +: 2]};
        e.rn   = {2'b00, b[`CPHC_B_RN +: 2]};
        e.rm   = {2'b00, b[`CPHC_B_RD +: 2]};
        e.imm  = {31'h00000000, b[0]};
      end
      default: begin
        e.op   = cphc_op_t'(d.word[`CPHC_F_OP +: 3]);
        e.size = (d.word[`CPHC_F_SIZE +: 2] == 2'b11) ? SZ_WORD : cphc_size_t'(d.word[`CPHC_F_SIZE +: 2]);
        e.rd   = d.word[`CPHC_F_RD +: 4];
        e.rn   = d.word[`CPHC_F_RN +: 4];
        e.rm   = d.word[`CPHC_F_RM +: 4];
        e.imm  = {18'h00000, d.word[`CPHC_W_IMM - 1:0]};
      end
    endcase
    e.valid  = d.valid;
    e.use_rn = e.op != OP_NOP;
    e.use_rm = e.op == OP_ADD || e.op == OP_STORE || e.op == OP_CPST || e.op == OP_SWAP;
    e.wr     = e.op == OP_ADD || e.op == OP_ADDI || e.op == OP_LOAD || e.op == OP_SWAP;
    return e;
  endfunction : decode_instr

  // Little-endian lane pick, zero-extended
  function automatic logic [31:0] load_extract(input logic [31:0] w, input logic [1:0] a, input cphc_size_t s);
    case (s)
      SZ_BYTE: load_extract = {24'h000000, w[{a, 3'b000} +: 8]};
      SZ_HALF: load_extract = {16'h0000, w[{a[1], 4'h0} +: 16]};
      default: load_extract = w;
    endcase
  endfunction : load_extract

  function automatic logic [31:0] operand(input cphc_fwd_t f, input logic [31:0] r, input logic [31:0] m,
                                          input logic [31:0] w);
    case (f)
      FWD_MEM: operand = m;
      FWD_WB:  operand = w;
      default: operand = r;
    endcase
  endfunction : operand

  cphc_hazard u_hazard (
    .dec_info (dx),
    .ex_st    (ex_ff),
    .mem_st   (mem_ff),
    .wb_st    (wb_ff),
    .load_use (load_use),
    .fwd_a    (fwd_a),
    .fwd_b    (fwd_b)
  );

  always_comb begin
    dx         = decode_instr(dec_ff);
    mem_wait   = dreq_ff.req && !dmem_ready;
    swap_first = mem_ff.valid && mem_ff.op == OP_SWAP && !swap_ph_ff;
    mem_hold   = mem_wait || swap_first;
    // First of the two bytecode decode cycles emits a bubble
    bc_wait    = dec_ff.valid && dec_ff.isa == ISA_BYTECODE && !bc_ph_ff;
    dec_hold   = load_use || bc_wait;
    op_a       = operand(fwd_a, rf_ff[ex_ff.rn], mem_ff.res, wb_ff.data);
    op_b       = operand(fwd_b, rf_ff[ex_ff.rm], mem_ff.res, wb_ff.data);
    ex_addr    = op_a + ex_ff.imm;
    misalign   = (ex_ff.size == SZ_WORD && ex_addr[1:0] != 2'b00) ||
                 (ex_ff.size == SZ_HALF && ex_addr[0]);
  end

  always_comb begin
    nxt_pc      = pc_ff;
    nxt_ireq    = 1'b1;
    nxt_dec     = dec_ff;
    nxt_ex      = ex_ff;
    nxt_mem     = mem_ff;
    nxt_wb      = '0;
    nxt_dreq    = dreq_ff;
    nxt_bc_ph   = bc_ph_ff;
    nxt_swap_ph = swap_ph_ff;
    nxt_swap_ld = swap_ld_ff;
    nxt_aerr    = 1'b0;
    nxt_stall   = dec_hold || mem_hold;
    if (mem_hold) begin
      // Whole pipe freezes; writeback gets the bubble
      if (swap_first && !mem_wait) begin
        nxt_swap_ph = 1'b1;
        nxt_swap_ld = load_extract(dmem_rdata, dreq_ff.addr[1:0], dreq_ff.size);
        nxt_dreq.we = 1'b1;
        nxt_dreq.req = 1'b1;
      end
    end else begin
      nxt_swap_ph = 1'b0;
      nxt_wb.valid = mem_ff.valid;
      nxt_wb.rd    = mem_ff.rd;
      nxt_wb.wr    = mem_ff.valid && mem_ff.wr;
      case (mem_ff.op)
        OP_LOAD: nxt_wb.data = load_extract(dmem_rdata, dreq_ff.addr[1:0], dreq_ff.size);
        OP_SWAP: nxt_wb.data = swap_ld_ff;
        default: nxt_wb.data = mem_ff.res;
      endcase
      nxt_mem       = '0;
      nxt_dreq      = '0;
      nxt_mem.valid = ex_ff.valid;
      nxt_mem.op    = ex_ff.op;
      nxt_mem.size  = ex_ff.size;
      nxt_mem.rd    = ex_ff.rd;
      nxt_mem.wr    = ex_ff.valid && ex_ff.wr;
      case (ex_ff.op)
        OP_ADD:  nxt_mem.res = op_a + op_b;
        OP_ADDI: nxt_mem.res = ex_addr;
        default: nxt_mem.res = 32'h0000_0000;
      endcase
      if (ex_ff.valid && ex_ff.op != OP_NOP && ex_ff.op != OP_ADD && ex_ff.op != OP_ADDI) begin
        nxt_dreq.req  = 1'b1;
        nxt_dreq.we   = ex_ff.op == OP_STORE || ex_ff.op == OP_CPST;
        nxt_dreq.size = ex_ff.size;
        // Low bits forced clear so memory never sees a split access
        case (ex_ff.size)
          SZ_WORD: nxt_dreq.addr = {ex_addr[31:2], 2'b00};
          SZ_HALF: nxt_dreq.addr = {ex_addr[31:1], 1'b0};
          default: nxt_dreq.addr = ex_addr;
        endcase
        case (ex_ff.size)
          SZ_BYTE: nxt_dreq.wdata = {4{op_b[7:0]}};
          SZ_HALF: nxt_dreq.wdata = {2{op_b[15:0]}};
          default: nxt_dreq.wdata = op_b;
        endcase
        nxt_aerr = misalign;
      end
      if (dec_hold) begin
        nxt_ex    = '0;
        nxt_bc_ph = bc_wait ? 1'b1 : bc_ph_ff;
      end else begin
        nxt_ex    = dx;
        nxt_bc_ph = 1'b0;
        nxt_dec   = '0;
        // Fetch proceeds beside the data access on its own bus
        if (imem_ready) begin
          nxt_dec.valid = 1'b1;
          nxt_dec.isa   = isa_state;
          nxt_dec.pc    = pc_ff;
          nxt_dec.word  = imem_rdata;
          case (isa_state)
            ISA_COMPACT:  nxt_pc = pc_ff + `CPHC_STEP_COMPACT;
            ISA_BYTECODE: nxt_pc = pc_ff + `CPHC_STEP_BYTE;
            default:      nxt_pc = pc_ff + `CPHC_STEP_NATIVE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff      <= `CPHC_RESET_PC;
      ireq_ff    <= 1'b0;
      dec_ff     <= '0;
      ex_ff      <= '0;
      mem_ff     <= '0;
      wb_ff      <= '0;
      dreq_ff    <= '0;
      bc_ph_ff   <= 1'b0;
      swap_ph_ff <= 1'b0;
      swap_ld_ff <= 32'h0000_0000;
      aerr_ff    <= 1'b0;
      stall_ff   <= 1'b0;
    end else begin
      pc_ff      <= nxt_pc;
      ireq_ff    <= nxt_ireq;
      dec_ff     <= nxt_dec;
      ex_ff      <= nxt_ex;
      mem_ff     <= nxt_mem;
      wb_ff      <= nxt_wb;
      dreq_ff    <= nxt_dreq;
      bc_ph_ff   <= nxt_bc_ph;
      swap_ph_ff <= nxt_swap_ph;
      swap_ld_ff <= nxt_swap_ld;
      aerr_ff    <= nxt_aerr;
      stall_ff   <= nxt_stall;
    end
  end

  always_comb begin
    nxt_rf = rf_ff;
    if (wb_ff.valid && wb_ff.wr) begin
      nxt_rf[wb_ff.rd] = wb_ff.data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        rf_ff[i] <= 32'h0000_0000;
      end
    end else begin
      rf_ff <= nxt_rf;
    end
  end

  assign imem_req  = ireq_ff;
  assign pc        = pc_ff;
  assign dmem      = dreq_ff;
  assign retire    = wb_ff;
  assign align_err = aerr_ff;
  assign stall     = stall_ff;

endmodule : cphc_pipe

// *** tb/cphc_pipe_props.sv ***
/*
  Port checker of the pipeline control.
  Assumes a bind to cphc_pipe from the bench top file.
*/
`timescale 1ns/1ps

module cphc_pipe_props (
  input wire logic            clk,
  input wire logic            rstn,
  input cphc_pkg::cphc_isa_t  isa_state,
  input wire logic            dmem_ready,
  input wire logic            imem_req,
  input wire logic [31:0]     pc,
  input cphc_pkg::cphc_dreq_t dmem,
  input wire logic            align_err,
  input wire logic            stall
);
  import cphc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_pc_step;
    !$stable(pc) |-> pc == $past(pc) + (($past(isa_state) == ISA_NATIVE) ? 32'h4 :
                                        ($past(isa_state) == ISA_COMPACT) ? 32'h2 : 32'h1);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_bc_two;
    $past(isa_state) == ISA_BYTECODE && !$stable(pc) |=> $stable(pc) && stall;
  endproperty
  a_bc_two: assert property (p_bc_two) else $error("bytecode decode not two cycles");
  property p_stall_hold;
    stall |-> $stable(pc);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("fetch moved while held");
  property p_imem_req;
    $past(rstn) |-> imem_req;
  endproperty
  a_imem_req: assert property (p_imem_req) else $error("fetch request dropped");
  property p_dmem_hold;
    dmem.req && !dmem_ready |=> $stable(dmem);
  endproperty
  a_dmem_hold: assert property (p_dmem_hold) else $error("data request changed early");
  property p_data_wait;
    dmem.req && !dmem_ready |=> stall;
  endproperty
  a_data_wait: assert property (p_data_wait) else $error("data wait not stalled");
  property p_aligned;
    dmem.req |-> (dmem.size == SZ_WORD) ? dmem.addr[1:0] == 2'h0 : (dmem.size != SZ_HALF || !dmem.addr[0]);
  endproperty
  a_aligned: assert property (p_aligned) else $error("unaligned data address");
  property p_size_legal;
    dmem.req |-> dmem.size != 2'h3;
  endproperty
  a_size_legal: assert property (p_size_legal) else $error("bad data size");
  property p_align_pulse;
    align_err |-> dmem.req && dmem.size != SZ_BYTE;
  endproperty
  a_align_pulse: assert property (p_align_pulse) else $error("stray alignment flag");

  c_stall: cover property ($rose(stall));
  c_align: cover property (align_err);
  c_write: cover property (dmem.req && dmem.we && dmem_ready);
endmodule : cphc_pipe_props

// *** tb/cphc_mem_model.sv ***
/*
  Instruction and data memories facing the pipeline control.
  Assumes the bench loads imem and dram directly and sets wait_cyc.
*/
`timescale 1ns/1ps

module cphc_mem_model (
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic [3:0]      wait_cyc,
  input wire logic            imem_req,
  input wire logic [31:0]     pc,
  input cphc_pkg::cphc_dreq_t dmem,
  output logic [31:0]         imem_rdata,
  output logic                imem_ready,
  output logic [31:0]         dmem_rdata,
  output logic                dmem_ready
);
  import cphc_pkg::*;
  logic [31:0] imem [0:63];
  logic [31:0] dram [0:63];
  logic [3:0]  wcnt;
  logic [3:0]  be;
  logic [31:0] word;

  // Own port each side, so fetch never waits on data
  assign imem_ready = imem_req;
  assign imem_rdata = imem_req ? imem[pc[7:2]] : ~pc;
  assign word       = dram[dmem.addr[7:2]];
  assign dmem_ready = dmem.req && (wcnt == wait_cyc);
  // Inverted while not answering, so a stale read cannot pass
  assign dmem_rdata = dmem_ready ? word : ~word;

  always_comb begin
    case (dmem.size)
      SZ_BYTE: be = 4'h1 << dmem.addr[1:0];
      SZ_HALF: be = 4'h3 << {dmem.addr[1], 1'b0};
      default: be = 4'hF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wcnt <= 4'h0;
    else if (!dmem.req || dmem_ready) wcnt <= 4'h0;
    else wcnt <= wcnt + 4'h1;
  end

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (dmem_ready && dmem.we && be[i]) dram[dmem.addr[7:2]][8*i +: 8] <= dmem.wdata[8*i +: 8];
    end
  end
endmodule : cphc_mem_model

// *** tb/core_pipeline_hazard_control_tb_top.sv ***
/*
  Bench of the pipeline control: small programs through the memory model.
  Assumes cphc_pipe, cphc_mem_model and cphc_pipe_props compiled before.
*/
`timescale 1ns/1ps

module core_pipeline_hazard_control_tb_top;
  import cphc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  cphc_isa_t   isa_state = ISA_NATIVE;
  logic [3:0]  wait_cyc = 4'h0;
  logic [31:0] imem_rdata;
  logic [31:0] dmem_rdata;
  logic [31:0] pc;
  logic        imem_ready;
  logic        dmem_ready;
  logic        imem_req;
  logic        align_err;
  logic        stall;
  cphc_dreq_t  dmem;
  cphc_wb_t    retire;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n_xfer;
  int          n_align;
  int          n_stall;
  logic [35:0] rq[$];

  always #10 clk = ~clk;

  cphc_pipe dut (.clk(clk), .rstn(rstn), .isa_state(isa_state), .imem_rdata(imem_rdata),
    .imem_ready(imem_ready), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready), .imem_req(imem_req),
    .pc(pc), .dmem(dmem), .retire(retire), .align_err(align_err), .stall(stall));
  cphc_mem_model mem (.clk(clk), .rstn(rstn), .wait_cyc(wait_cyc), .imem_req(imem_req), .pc(pc),
    .dmem(dmem), .imem_rdata(imem_rdata), .imem_ready(imem_ready), .dmem_rdata(dmem_rdata),
    .dmem_ready(dmem_ready));

  always @(posedge clk) begin
    cyc++;
    if (rstn && retire.valid && retire.wr) rq.push_back({retire.rd, retire.data});
    if (rstn && dmem_ready) n_xfer++;
    if (rstn && align_err) n_align++;
    if (rstn && stall) n_stall++;
    if (cyc == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input int i, input logic [35:0] e);
    chk((i < rq.size()) ? rq[i] : 36'hF_FFFF_FFFF, e);
  endtask : rchk

  function automatic logic [31:0] ni(cphc_op_t op, cphc_size_t sz, logic [3:0] rd, logic [3:0] rn,
                                     logic [3:0] rm, logic [13:0] imm);
    return {1'b0, op, sz, rd, rn, rm, imm};
  endfunction : ni

  task automatic clr;
    foreach (mem.imem[i]) mem.imem[i] = 32'h0;
    foreach (mem.dram[i]) mem.dram[i] = 32'h0;
  endtask : clr

  task automatic run(input cphc_isa_t isa, input logic [3:0] wt, input int n);
    @(negedge clk);
    rstn = 1'b0;
    isa_state = isa;
    wait_cyc = wt;
    repeat (2) @(negedge clk);
    chk({pc, imem_req, dmem.req, stall}, 35'h0);
    rq.delete();
    n_xfer = 0;
    n_align = 0;
    n_stall = 0;
    rstn = 1'b1;
    repeat (n) @(negedge clk);
  endtask : run

  task automatic t_alu;
    clr();
    mem.imem[0] = ni(OP_ADDI, SZ_WORD, 4'h1, 4'h0, 4'h0, 14'h5);
    mem.imem[1] = ni(OP_ADDI, SZ_WORD, 4'h2, 4'h0, 4'h0, 14'h7);
    mem.imem[2] = ni(OP_ADD, SZ_WORD, 4'h3, 4'h1, 4'h2, 14'h0);
    mem.imem[3] = ni(OP_ADD, SZ_WORD, 4'h4, 4'h3, 4'h3, 14'h0);
    run(ISA_NATIVE, 4'h0, 20);
    chk(rq.size(), 64'h4);
    rchk(0, {4'h1, 32'h5});
    rchk(1, {4'h2, 32'h7});
    rchk(2, {4'h3, 32'hC});
    rchk(3, {4'h4, 32'h18});
    chk(n_xfer, 64'h0);
    chk(n_stall, 64'h0);
  endtask : t_alu

  // Load-use, every data size, swap, coprocessor transfers, misaligned word
  task automatic t_mem(input logic [3:0] wt);
    clr();
    mem.imem[0] = ni(OP_ADDI, SZ_WORD, 4'h1, 4'h0, 4'h0, 14'h1234);
    mem.imem[1] = ni(OP_STORE, SZ_WORD, 4'h0, 4'h0, 4'h1, 14'h40);
    mem.imem[2] = ni(OP_LOAD, SZ_BYTE, 4'h2, 4'h0, 4'h0, 14'h41);
    mem.imem[3] = ni(OP_ADD, SZ_WORD, 4'h3, 4'h2, 4'h1, 14'h0);
    mem.imem[4] = ni(OP_STORE, SZ_HALF, 4'h0, 4'h0, 4'h3, 14'h46);
    mem.imem[5] = ni(OP_LOAD, SZ_WORD, 4'h4, 4'h0, 4'h0, 14'h44);
    mem.imem[6] = ni(OP_SWAP, SZ_WORD, 4'h5, 4'h0, 4'h3, 14'h40);
    mem.imem[7] = ni(OP_CPLD, SZ_WORD, 4'h0, 4'h0, 4'h0, 14'h50);
    mem.imem[8] = ni(OP_CPST, SZ_WORD, 4'h0, 4'h0, 4'h1, 14'h54);
    mem.imem[9] = ni(OP_LOAD, SZ_WORD, 4'h6, 4'h0, 4'h0, 14'h47);
    // Length follows the wait count so pc never wraps past the model's 64 words
    run(ISA_NATIVE, wt, 40 + 12 * int'(wt));
    chk(rq.size(), 64'h6);
    rchk(0, {4'h1, 32'h1234});
    rchk(1, {4'h2, 32'h12});
    rchk(2, {4'h3, 32'h1246});
    rchk(3, {4'h4, 32'h1246_0000});
    rchk(4, {4'h5, 32'h1234});
    rchk(5, {4'h6, 32'h1246_0000});
    chk(mem.dram[16], 64'h1246);
    chk(mem.dram[21], 64'h1234);
    chk(n_xfer, 64'h9);
    chk(n_align, 64'h1);
    chk(n_stall != 0, 64'h1);
  endtask : t_mem

  task automatic t_bytecode;
    clr();
    mem.imem[0] = 32'h4B4B_4B4B;
    run(ISA_BYTECODE, 4'h0, 30);
    chk(rq.size(), 64'h4);
    for (int i = 0; i < 4; i++) begin
      rchk(i, {4'h1, 32'(i + 1)});
    end
    chk(n_stall >= 4, 64'h1);
  endtask : t_bytecode

  task automatic t_compact;
    clr();
    mem.imem[0] = 32'h4903_4903;
    run(ISA_COMPACT, 4'h0, 20);
    chk(rq.size(), 64'h2);
    rchk(0, {4'h2, 32'h3});
    rchk(1, {4'h2, 32'h6});
  endtask : t_compact

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(negedge clk);
    t_alu();
    t_mem(4'h0);
    t_mem(4'h3);
    t_bytecode();
    t_compact();
    print_verdict();
  end
endmodule : core_pipeline_hazard_control_tb_top

bind cphc_pipe cphc_pipe_props u_props (.clk(clk), .rstn(rstn), .isa_state(isa_state),
  .dmem_ready(dmem_ready), .imem_req(imem_req), .pc(pc), .dmem(dmem), .align_err(align_err), .stall(stall));
